// [inc/supervisory_timer_pkg.sv]
package supervisory_timer_pkg;

  // ----------------------------------------------------------------
  // timeout selection
  // ----------------------------------------------------------------
  localparam int SEL_W = 2;
  localparam int COUNT_W = 18;
  // timeout = 2^(base + 2*sel) oscillator ticks
  localparam int SHIFT_BASE = 12;
  localparam int SHIFT_STEP = 2;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESET = 18'h00000;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic LOCK_RESET = 1'b0;

endpackage

// [test/supervisory_timer_bench.sv]
`timescale 1ns/100ps
module supervisory_timer_bench;
  // --------------------------------
  // stimulus and design
  // --------------------------------
  localparam int LIM = 1 << supervisory_timer_pkg::SHIFT_BASE;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic low_freq_osc = 1'b0;
  logic sw_restart = 1'b0;
  logic sw_disable = 1'b0;
  logic sw_lock = 1'b0;
  logic sw_interval_wr = 1'b0;
  logic [supervisory_timer_pkg::SEL_W-1:0] sw_interval = 2'h0;
  logic wdt_reset;
  logic running;
  logic locked;
  logic [supervisory_timer_pkg::SEL_W-1:0] interval;
  logic rst_pin_oe;
  int n_fail = 0;
  int checks = 0;

  always #10 mclk = ~mclk;

  supervisory_timer supervisory_timer_inst (.mclk(mclk), .reset_n(reset_n),
    .low_freq_osc(low_freq_osc), .sw_restart(sw_restart), .sw_disable(sw_disable),
    .sw_lock(sw_lock), .sw_interval_wr(sw_interval_wr), .sw_interval(sw_interval),
    .wdt_reset(wdt_reset), .running(running), .locked(locked), .interval(interval),
    .rst_pin_oe(rst_pin_oe));

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle request, then one more cycle so the answer has landed
  task automatic drive(input logic r, input logic d, input logic l, input logic w,
                       input logic [1:0] s);
    @(negedge mclk);
    {sw_restart, sw_disable, sw_lock, sw_interval_wr, sw_interval} = {r, d, l, w, s};
    @(negedge mclk);
    {sw_restart, sw_disable, sw_lock, sw_interval_wr} = 4'h0;
    @(negedge mclk);
  endtask

  // six mclk per oscillator period keeps long timeouts affordable
  task automatic ticks(input int n);
    repeat (n) begin
      low_freq_osc = 1'b1;
      repeat (3) @(negedge mclk);
      low_freq_osc = 1'b0;
      repeat (3) @(negedge mclk);
    end
  endtask

  task automatic do_reset;
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic test_reset_state;
    do_reset();
    chk(running, 1'b1);
    chk(interval, supervisory_timer_pkg::SEL_RESET);
    chk(locked, 1'b0);
    chk(wdt_reset, 1'b0);
  endtask

  task automatic test_config;
    for (int i = 0; i < 4; i++) begin
      drive(1'b0, 1'b0, 1'b0, 1'b1, 2'(i));
      chk(interval, 4'(i));
    end
    drive(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    chk(running, 1'b0);
  endtask

  task automatic test_overflow;
    do_reset();
    drive(1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
    ticks(LIM - 96);
    drive(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    ticks(LIM - 1);
    // oscillator idle: mclk alone must not advance the count
    repeat (5000) @(negedge mclk);
    chk(wdt_reset, 1'b0);
    ticks(1);
    repeat (4) @(negedge mclk);
    chk(wdt_reset, 1'b1);
    chk(rst_pin_oe, 1'b0);
  endtask

  task automatic test_lock;
    do_reset();
    drive(1'b0, 1'b0, 1'b1, 1'b0, 2'h0);
    chk({locked, running}, 2'h3);
    drive(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    chk(running, 1'b1);
    drive(1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
    chk(interval, supervisory_timer_pkg::SEL_RESET);
    do_reset();
    chk(locked, 1'b0);
  endtask

  initial begin
    test_reset_state();
    test_config();
    test_overflow();
    test_lock();
    finish_test();
  end

  // about 54k cycles expected; 90k means a hang
  initial begin
    #1800000;
    n_fail++;
    finish_test();
  end
endmodule

// [verilog/low_freq_edge.sv]
`timescale 1ns/100ps
module low_freq_edge (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic low_freq_osc,
  output logic tick
);

  // ----------------------------------------------------------------
  // synchroniser and rising edge detect
  // ----------------------------------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic tick_ff;

  // meta_ff feeds only sync_ff
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= low_freq_osc;
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      prev_ff <= sync_ff;
      tick_ff <= sync_ff & ~prev_ff;
    end
  end

  assign tick = tick_ff;

endmodule

// [verilog/supervisory_timer.sv]
`timescale 1ns/100ps
//
// Overview of operation
// - overflow asserts a whole-device system reset
// - software restart clears count, avoiding reset
// - after reset: enabled, counting, longest interval
// - software may disable or lock on
// - once locked, disable ignored until reset
// - locked configuration frozen, interval included
// - external reset pin never driven by watchdog
// - counting paced by low frequency oscillator
//
module supervisory_timer (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic low_freq_osc,
  input wire logic sw_restart,
  input wire logic sw_disable,
  input wire logic sw_lock,
  input wire logic sw_interval_wr,
  input wire logic [supervisory_timer_pkg::SEL_W-1:0] sw_interval,
  output logic wdt_reset,
  output logic running,
  output logic locked,
  output logic [supervisory_timer_pkg::SEL_W-1:0] interval,
  output logic rst_pin_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic tick;
  logic enable_ff;
  logic lock_ff;
  logic reset_ff;
  logic pin_oe_ff;
  logic [supervisory_timer_pkg::SEL_W-1:0] sel_ff;
  logic [supervisory_timer_pkg::COUNT_W-1:0] count_ff;
  logic [supervisory_timer_pkg::COUNT_W-1:0] nxt_count;
  logic at_limit;

  function automatic logic [supervisory_timer_pkg::COUNT_W-1:0] limit_of(
    input logic [supervisory_timer_pkg::SEL_W-1:0] sel
  );
    int sh;
    logic [63:0] full;
    sh = supervisory_timer_pkg::SHIFT_BASE + supervisory_timer_pkg::SHIFT_STEP * int'(sel);
    full = (64'h1 << sh) - 64'h1;
    limit_of = full[supervisory_timer_pkg::COUNT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // oscillator tick
  // ----------------------------------------------------------------
  // count follows the oscillator, so system clock changes do not move it
  low_freq_edge low_freq_edge_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .low_freq_osc(low_freq_osc),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  // lock wins over a disable in the same cycle, so a race cannot open it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enable_ff <= supervisory_timer_pkg::ENABLE_RESET;
      lock_ff <= supervisory_timer_pkg::LOCK_RESET;
    end else if (sw_lock) begin
      enable_ff <= 1'b1;
      lock_ff <= 1'b1;
    end else if (sw_disable && !lock_ff) begin
      enable_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff <= supervisory_timer_pkg::SEL_RESET;
    end else if (sw_interval_wr && !lock_ff) begin
      sel_ff <= sw_interval;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // at or past the limit, so a shorter interval chosen mid-count cannot wrap the counter
  assign at_limit = (count_ff >= limit_of(sel_ff));

  always_comb begin
    nxt_count = count_ff;
    if (!enable_ff || sw_restart) begin
      nxt_count = supervisory_timer_pkg::COUNT_RESET;
    end else if (tick && !at_limit) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= supervisory_timer_pkg::COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------------------------------
  // reset request
  // ----------------------------------------------------------------
  // held until the system reset it causes comes back on reset_n
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reset_ff <= 1'b0;
    end else if (enable_ff && tick && at_limit && !sw_restart) begin
      reset_ff <= 1'b1;
    end
  end

  // internal reset only; the pin driver stays off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_ff <= 1'b0;
    end else begin
      pin_oe_ff <= 1'b0;
    end
  end

  assign wdt_reset = reset_ff;
  assign running = enable_ff;
  assign locked = lock_ff;
  assign interval = sel_ff;
  assign rst_pin_oe = pin_oe_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_overflow;
    @(posedge mclk) disable iff (!reset_n)
    enable_ff && tick && at_limit && !sw_restart |=> wdt_reset;
  endproperty
  a_overflow: assert property (p_overflow) else $error("no reset on overflow");

  property p_restart;
    @(posedge mclk) disable iff (!reset_n)
    sw_restart |=> count_ff == supervisory_timer_pkg::COUNT_RESET && !$rose(wdt_reset);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear count");

  property p_reset_state;
    @(posedge mclk) disable iff (!reset_n)
    !$past(reset_n) |-> running && !locked && interval == supervisory_timer_pkg::SEL_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_disable;
    @(posedge mclk) disable iff (!reset_n)
    sw_disable && !sw_lock && !locked |=> !running ##1 count_ff == 18'h00000;
  endproperty
  a_disable: assert property (p_disable) else $error("disable not taken");

  property p_lock;
    @(posedge mclk) disable iff (!reset_n)
    sw_lock |=> locked && running;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not taken");

  property p_lock_hold;
    @(posedge mclk) disable iff (!reset_n)
    locked |=> (locked && running)[*2];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked timer released");

  property p_frozen;
    @(posedge mclk) disable iff (!reset_n)
    locked && sw_interval_wr |=> $stable(interval);
  endproperty
  a_frozen: assert property (p_frozen) else $error("locked interval changed");

  property p_pin;
    @(posedge mclk) disable iff (!reset_n)
    $rose(wdt_reset) |-> !rst_pin_oe ##1 !rst_pin_oe;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin driven");

  property p_paced;
    @(posedge mclk) disable iff (!reset_n)
    !tick && !sw_restart && running |=> $stable(count_ff);
  endproperty
  a_paced: assert property (p_paced) else $error("count moved without tick");

  property p_interval_wr;
    @(posedge mclk) disable iff (!reset_n)
    sw_interval_wr && !locked |=> interval == $past(sw_interval);
  endproperty
  a_interval_wr: assert property (p_interval_wr) else $error("interval write lost");

  property p_sticky;
    @(posedge mclk) disable iff (!reset_n)
    wdt_reset |=> wdt_reset;
  endproperty
  a_sticky: assert property (p_sticky) else $error("reset request dropped");

  property p_step;
    @(posedge mclk) disable iff (!reset_n)
    tick && running && !at_limit && !sw_restart |=> count_ff == $past(count_ff) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("tick did not advance count");

  property p_idle;
    @(posedge mclk) disable iff (!reset_n)
    !running |=> count_ff == supervisory_timer_pkg::COUNT_RESET && !$rose(wdt_reset);
  endproperty
  a_idle: assert property (p_idle) else $error("disabled timer counted");

  c_overflow: cover property (@(posedge mclk) disable iff (!reset_n) $rose(wdt_reset));
  c_lock: cover property (@(posedge mclk) disable iff (!reset_n) sw_lock ##[1:8] sw_disable);
  c_refuse: cover property (@(posedge mclk) disable iff (!reset_n) locked && sw_interval_wr);
  c_select: cover property (@(posedge mclk) disable iff (!reset_n) sw_interval_wr && !locked);
  c_restart: cover property (@(posedge mclk) disable iff (!reset_n) tick ##[1:50] sw_restart);

endmodule
